/* hdl/plt_top.sv */
// module: phy loopback test control top with registers and lane routing
//
// Summary of operation
// - a serial bit forces its lane's master loopback on.
// - a parallel bit sets its lane's slave loopback on or off.
// - slave loopback also comes on while the port is active slave.
// - a user pattern bit makes its serdes send the user pattern.
// - a loopback command sends the port toward loopback master.
// - entry is via linkwidth start before configuration, else recovery.
// - scrambler disable bypasses scrambling and sets the training bit.
// - a disable applies at once while the link is down, else in config complete.
// - compliance receive marks training sets in polling and entry only.
// - the ready flag is one while a port under its loopback command is active loopback master.
// - an established master holds active loopback while commanded.
// - analog loopback moves loopback ahead of the buffer, over parallel.
// - ports 1 to 3 repeat the command group at bits 4, 8 and 12.
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/100ps
module plt_top (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic eeprom_ld_i,
    input wire logic [31:0] eeprom_test_i,
    input wire logic [31:0] eeprom_cmd_i,
    input wire logic port0_x2_i,
    input wire logic [15:0] ltssm_i,
    input wire logic [3:0] lb_master_i,
    input wire logic [3:0] lb_slave_i,
    output logic [3:0] serial_lb_o,
    output logic [3:0] parallel_lb_o,
    output logic [3:0] analog_lb_o,
    output logic [3:0] user_pattern_tx_o,
    output logic [3:0] scr_bypass_o,
    output logic [3:0] tcb_scr_off_o,
    output logic [3:0] tcb_crx_o,
    output logic [3:0] lb_req_cfg_o,
    output logic [3:0] lb_req_rec_o,
    output logic [3:0] lb_hold_o
);
    logic [31:0] test_ctl_r;
    logic [31:0] port_cmd_r;
    logic [3:0] ready_master;
    logic [3:0] lane_slave_act;
    logic wr_stb;
    logic rd_stb;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic cmd_wr;
    logic [3:0] port_scr;

    // --------------------------------------------------------------
    // lane to port ownership
    // --------------------------------------------------------------
    function automatic logic [1:0] lane_owner(input logic [1:0] lane, input logic x2);
        lane_owner = (lane == 2'h1 && x2) ? 2'h0 : lane;
    endfunction

    // --------------------------------------------------------------
    // bus slave
    // --------------------------------------------------------------
    plt_ahb_slave u_bus (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hsize_i(hsize_i),
        .hready_i(hready_i),
        .hwdata_i(hwdata_i),
        .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o),
        .wr_stb_o(wr_stb),
        .rd_stb_o(rd_stb),
        .addr_o(addr),
        .wdata_o(wdata)
    );

    assign cmd_wr = wr_stb && (addr == plt_pkg::PHY_PORT_COMMAND_OFS);

    // --------------------------------------------------------------
    // registers; an eeprom load wins over a bus write
    // --------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            test_ctl_r <= plt_pkg::PHY_TEST_CONTROL_RST;
        end else if (eeprom_ld_i) begin
            test_ctl_r <= eeprom_test_i & plt_pkg::TEST_CONTROL_WMASK;
        end else if (wr_stb && addr == plt_pkg::PHY_TEST_CONTROL_OFS) begin
            test_ctl_r <= wdata & plt_pkg::TEST_CONTROL_WMASK;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_cmd_r <= plt_pkg::PHY_PORT_COMMAND_RST;
        end else if (eeprom_ld_i) begin
            port_cmd_r <= eeprom_cmd_i & plt_pkg::PORT_COMMAND_WMASK;
        end else if (cmd_wr) begin
            port_cmd_r <= wdata & plt_pkg::PORT_COMMAND_WMASK;
        end
    end

    // read data taken in the address phase; ready flags spliced in
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (rd_stb) begin
            case (haddr_i[11:0])
                plt_pkg::PHY_TEST_CONTROL_OFS: hrdata_o <= test_ctl_r;
                plt_pkg::PHY_PORT_COMMAND_OFS: begin
                    hrdata_o <= port_cmd_r;
                    for (int p = 0; p < plt_pkg::NUM_PORTS; p++) begin
                        hrdata_o[p*plt_pkg::CMD_GROUP_WIDTH + plt_pkg::CMD_READY_MASTER_BIT]
                            <= ready_master[p];
                    end
                end
                default: hrdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // --------------------------------------------------------------
    // per-port sequencers
    // --------------------------------------------------------------
    for (genvar p = 0; p < plt_pkg::NUM_PORTS; p++) begin : g_port
        localparam int B = p * plt_pkg::CMD_GROUP_WIDTH;
        plt_port_ctrl u_port (
            .core_clk_i(core_clk_i),
            .rst_n_i(rst_n_i),
            .lb_cmd_i(port_cmd_r[B + plt_pkg::CMD_LOOPBACK_BIT]),
            .scr_cmd_i(port_cmd_r[B + plt_pkg::CMD_SCRAMBLE_OFF_BIT]),
            .scr_sw_wr_i(cmd_wr && wdata[B + plt_pkg::CMD_SCRAMBLE_OFF_BIT]),
            .crx_cmd_i(port_cmd_r[B + plt_pkg::CMD_COMPLIANCE_RX_BIT]),
            .ltssm_i(ltssm_i[p*4 +: 4]),
            .lb_master_i(lb_master_i[p]),
            .lb_req_cfg_o(lb_req_cfg_o[p]),
            .lb_req_rec_o(lb_req_rec_o[p]),
            .lb_hold_o(lb_hold_o[p]),
            .ready_master_o(ready_master[p]),
            .scr_bypass_o(port_scr[p]),
            .tcb_scr_off_o(tcb_scr_off_o[p]),
            .tcb_crx_o(tcb_crx_o[p])
        );
    end

    // --------------------------------------------------------------
    // lane path controls, all registered
    // --------------------------------------------------------------
    always_comb begin
        for (int l = 0; l < plt_pkg::NUM_LANES; l++) begin
            logic [1:0] o;
            o = lane_owner(2'(l), port0_x2_i);
            lane_slave_act[l] = (ltssm_i[o*4 +: 4] == plt_pkg::LT_LOOPBACK_ACTIVE) &&
                lb_slave_i[o];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_lb_o <= 4'h0;
            parallel_lb_o <= 4'h0;
            analog_lb_o <= 4'h0;
            user_pattern_tx_o <= 4'h0;
            scr_bypass_o <= 4'h0;
        end else begin
            for (int l = 0; l < plt_pkg::NUM_LANES; l++) begin
                logic an;
                an = test_ctl_r[plt_pkg::ANALOG_LB_BIT];
                serial_lb_o[l] <= test_ctl_r[plt_pkg::SERIAL_LB_LSB + l];
                analog_lb_o[l] <= an & (test_ctl_r[plt_pkg::PARALLEL_LB_LSB + l] |
                    lane_slave_act[l]);
                parallel_lb_o[l] <= ~an & (test_ctl_r[plt_pkg::PARALLEL_LB_LSB + l] |
                    lane_slave_act[l]);
                user_pattern_tx_o[l] <= test_ctl_r[plt_pkg::USER_PATTERN_TX_LSB + l];
                scr_bypass_o[l] <= port_scr[lane_owner(2'(l), port0_x2_i)];
            end
        end
    end
endmodule

/* pkg/plt_pkg.sv */
// package: register map, fields and substate codes of the phy loopback test block
package plt_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] PHY_TEST_CONTROL_OFS = 12'h228;
    localparam logic [11:0] PHY_PORT_COMMAND_OFS = 12'h230;
    localparam logic [31:0] PHY_TEST_CONTROL_RST = 32'h0000_0000;
    localparam logic [31:0] PHY_PORT_COMMAND_RST = 32'h0000_0000;
    // writable test control bits
    localparam logic [31:0] TEST_CONTROL_WMASK = 32'hfff0_0040;
    // writable command bits, three of each port group
    localparam logic [31:0] PORT_COMMAND_WMASK = 32'h0000_7777;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ANALOG_LB_BIT = 6;
    localparam int SERIAL_LB_LSB = 20;
    localparam int PARALLEL_LB_LSB = 24;
    localparam int USER_PATTERN_TX_LSB = 28;
    localparam int CMD_LOOPBACK_BIT = 0;
    localparam int CMD_SCRAMBLE_OFF_BIT = 1;
    localparam int CMD_COMPLIANCE_RX_BIT = 2;
    localparam int CMD_READY_MASTER_BIT = 3;
    localparam int CMD_GROUP_WIDTH = 4;
    localparam int NUM_LANES = 4;
    localparam int NUM_PORTS = 4;
    // ------------------------------------------------------------
    // training substates per port
    // ------------------------------------------------------------
    localparam logic [3:0] LT_DETECT_QUIET = 4'h0;
    localparam logic [3:0] LT_POLLING_ACTIVE = 4'h1;
    localparam logic [3:0] LT_CFG_LINKWIDTH_START = 4'h2;
    localparam logic [3:0] LT_CFG_COMPLETE = 4'h3;
    localparam logic [3:0] LT_L0 = 4'h4;
    localparam logic [3:0] LT_RECOVERY_IDLE = 4'h5;
    localparam logic [3:0] LT_LOOPBACK_ENTRY = 4'h6;
    localparam logic [3:0] LT_LOOPBACK_ACTIVE = 4'h7;
    // ------------------------------------------------------------
    // loopback sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PLT_LB_IDLE,
        PLT_LB_WAIT_CFG,
        PLT_LB_WAIT_REC,
        PLT_LB_HOLD
    } plt_lb_state_t;
endpackage

/* hdl/plt_ahb_slave.sv */
// module: ahb-lite slave front end giving one-cycle register strobes
`timescale 1ns/100ps
module plt_ahb_slave (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic wr_stb_o,
    output logic rd_stb_o,
    output logic [11:0] addr_o,
    output logic [31:0] wdata_o
);
    logic wr_pend_r;
    logic [11:0] addr_r;
    logic take;

    // --------------------------------------------------------------
    // address phase capture
    // --------------------------------------------------------------
    // word transfers only; narrower ones are dropped
    assign take = hsel_i & htrans_i[1] & hready_i & (hsize_i == 3'h2);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_pend_r <= 1'b0;
            addr_r <= 12'h000;
        end else begin
            wr_pend_r <= take & hwrite_i;
            if (take) begin
                addr_r <= haddr_i[11:0];
            end
        end
    end

    // write data arrive in the data phase, so the strobe lands there
    assign wr_stb_o = wr_pend_r;
    // reads are taken in the address phase so data stand in the data phase
    assign rd_stb_o = take & ~hwrite_i;
    assign addr_o = addr_r;
    assign wdata_o = hwdata_i;
    // zero wait states, always okay
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
endmodule

/* hdl/plt_port_ctrl.sv */
// module: per-port loopback master sequencer and training control bits
`timescale 1ns/100ps
module plt_port_ctrl (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic lb_cmd_i,
    input wire logic scr_cmd_i,
    input wire logic scr_sw_wr_i,
    input wire logic crx_cmd_i,
    input wire logic [3:0] ltssm_i,
    input wire logic lb_master_i,
    output logic lb_req_cfg_o,
    output logic lb_req_rec_o,
    output logic lb_hold_o,
    output logic ready_master_o,
    output logic scr_bypass_o,
    output logic tcb_scr_off_o,
    output logic tcb_crx_o
);
    plt_pkg::plt_lb_state_t st_r;
    logic scr_pend_r;
    logic in_lb_active;
    logic past_cfg;

    assign in_lb_active = (ltssm_i == plt_pkg::LT_LOOPBACK_ACTIVE);
    assign past_cfg = (ltssm_i == plt_pkg::LT_L0) || (ltssm_i == plt_pkg::LT_RECOVERY_IDLE);

    // --------------------------------------------------------------
    // loopback master request sequencing
    // --------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= plt_pkg::PLT_LB_IDLE;
        end else begin
            case (st_r)
                plt_pkg::PLT_LB_IDLE: begin
                    if (lb_cmd_i) begin
                        st_r <= past_cfg ? plt_pkg::PLT_LB_WAIT_REC : plt_pkg::PLT_LB_WAIT_CFG;
                    end
                end
                plt_pkg::PLT_LB_WAIT_CFG, plt_pkg::PLT_LB_WAIT_REC: begin
                    if (!lb_cmd_i) begin
                        st_r <= plt_pkg::PLT_LB_IDLE;
                    end else if (in_lb_active && lb_master_i) begin
                        st_r <= plt_pkg::PLT_LB_HOLD;
                    end
                end
                plt_pkg::PLT_LB_HOLD: begin
                    // hold until the command drops or the port leaves loopback active
                    if (!lb_cmd_i || !in_lb_active) begin
                        st_r <= plt_pkg::PLT_LB_IDLE;
                    end
                end
                default: st_r <= plt_pkg::PLT_LB_IDLE;
            endcase
        end
    end

    // --------------------------------------------------------------
    // scrambler disable: a live-link write waits for configuration
    // --------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scr_pend_r <= 1'b0;
            scr_bypass_o <= 1'b0;
        end else begin
            if (!scr_cmd_i) begin
                scr_pend_r <= 1'b0;
                scr_bypass_o <= 1'b0;
            end else if (ltssm_i == plt_pkg::LT_CFG_COMPLETE) begin
                scr_pend_r <= 1'b0;
                scr_bypass_o <= 1'b1;
            end else if (scr_sw_wr_i && !scr_bypass_o) begin
                scr_pend_r <= 1'b1;
            end else if (!scr_pend_r && !past_cfg) begin
                // link not up: a loaded bit applies at once
                scr_bypass_o <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------------
    // registered outputs
    // --------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lb_req_cfg_o <= 1'b0;
            lb_req_rec_o <= 1'b0;
            lb_hold_o <= 1'b0;
            ready_master_o <= 1'b0;
            tcb_scr_off_o <= 1'b0;
            tcb_crx_o <= 1'b0;
        end else begin
            lb_req_cfg_o <= lb_cmd_i && (st_r == plt_pkg::PLT_LB_WAIT_CFG);
            lb_req_rec_o <= lb_cmd_i && (st_r == plt_pkg::PLT_LB_WAIT_REC);
            lb_hold_o <= lb_cmd_i && (st_r == plt_pkg::PLT_LB_HOLD);
            ready_master_o <= in_lb_active && lb_master_i && (st_r != plt_pkg::PLT_LB_IDLE);
            tcb_scr_off_o <= scr_cmd_i;
            tcb_crx_o <= crx_cmd_i && ((ltssm_i == plt_pkg::LT_POLLING_ACTIVE) ||
                (ltssm_i == plt_pkg::LT_LOOPBACK_ENTRY));
        end
    end
endmodule

/* bench/plt_checker_props.sv */
// checker: port-level properties of the phy loopback test control block
`timescale 1ns/100ps
module plt_checker (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic port0_x2_i,
    input wire logic [15:0] ltssm_i,
    input wire logic [3:0] lb_master_i,
    input wire logic [3:0] lb_slave_i,
    input wire logic [3:0] parallel_lb_o,
    input wire logic [3:0] analog_lb_o,
    input wire logic [3:0] scr_bypass_o,
    input wire logic [3:0] tcb_crx_o,
    input wire logic [3:0] lb_req_cfg_o,
    input wire logic [3:0] lb_req_rec_o,
    input wire logic [3:0] lb_hold_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [3:0] lt0;
    // port 0 substate
    assign lt0 = ltssm_i[3:0];
    unmapped_read_a: assert property (hsel_i && htrans_i == 2'b10 && hready_i && !hwrite_i
        && hsize_i == 3'h2 && !(haddr_i[11:0] inside {12'h228, 12'h230}) |=> hrdata_o == 32'h0)
        else $error("unmapped read data");
    crx_window_a: assert property (tcb_crx_o[0] |-> $past(lt0) inside {4'h1, 4'h6})
        else $error("compliance bit out of window");
    lb_point_excl_a: assert property ((parallel_lb_o & analog_lb_o) == 4'h0)
        else $error("both loopback points on");
    slave_auto_a: assert property (lb_slave_i[0] && lt0 == 4'h7 |=>
        parallel_lb_o[0] || analog_lb_o[0]) else $error("slave path off");
    req_path_excl_a: assert property ((lb_req_cfg_o & lb_req_rec_o) == 4'h0)
        else $error("both entry paths");
    hold_cause_a: assert property ($rose(lb_hold_o[0]) |->
        ($past(lt0) == 4'h7 && $past(lb_master_i[0])) ||
        ($past(lt0, 2) == 4'h7 && $past(lb_master_i[0], 2))) else $error("hold without master");
    hold_no_req_a: assert property (lb_hold_o[0] |-> !(lb_req_cfg_o[0] || lb_req_rec_o[0]))
        else $error("request while holding");
    lane1_owner_a: assert property (port0_x2_i && $past(port0_x2_i) |->
        scr_bypass_o[1] == scr_bypass_o[0]) else $error("lane 1 owner wrong");
    bypass_link_up_a: assert property ($rose(scr_bypass_o[0]) |->
        !($past(lt0) inside {4'h4, 4'h5})) else $error("bypass while link up");
endmodule
// bind to the top
bind plt_top plt_checker u_plt_checker (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .port0_x2_i(port0_x2_i),
    .ltssm_i(ltssm_i), .lb_master_i(lb_master_i), .lb_slave_i(lb_slave_i),
    .parallel_lb_o(parallel_lb_o), .analog_lb_o(analog_lb_o), .scr_bypass_o(scr_bypass_o),
    .tcb_crx_o(tcb_crx_o), .lb_req_cfg_o(lb_req_cfg_o), .lb_req_rec_o(lb_req_rec_o),
    .lb_hold_o(lb_hold_o));

/* bench/plt_link_partner_model.sv */
// model: link partner face of the four training machines, loopback walk included
`timescale 1ns/100ps
module plt_link_partner_model (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] base_i,
    input wire logic [3:0] slave_i,
    input wire logic slow_i,
    input wire logic [3:0] lb_req_cfg_i,
    input wire logic [3:0] lb_req_rec_i,
    input wire logic [3:0] lb_hold_i,
    output logic [15:0] ltssm_o,
    output logic [3:0] lb_master_o,
    output logic [3:0] lb_slave_o
);
    logic [1:0] step_r [4];
    logic [3:0] cnt_r [4];
    logic [3:0] rec_r;
    // walk: path, entry, active; slow lingers in entry
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int p = 0; p < 4; p++) begin
                step_r[p] <= 2'd0;
                cnt_r[p] <= 4'h0;
            end
            rec_r <= 4'h0;
        end else begin
            for (int p = 0; p < 4; p++) begin
                cnt_r[p] <= cnt_r[p] + 4'h1;
                if (step_r[p] == 2'd0) begin
                    rec_r[p] <= lb_req_rec_i[p];
                    if (lb_req_cfg_i[p] || lb_req_rec_i[p]) step_r[p] <= 2'd1;
                end else if (step_r[p] == 2'd1) begin
                    step_r[p] <= 2'd2;
                    cnt_r[p] <= 4'h0;
                end else if (step_r[p] == 2'd2) begin
                    if (cnt_r[p] == (slow_i ? 4'hc : 4'h1)) step_r[p] <= 2'd3;
                end else if (lb_req_cfg_i[p] || lb_req_rec_i[p] || lb_hold_i[p]) begin
                    cnt_r[p] <= 4'h0;
                end else if (cnt_r[p] == 4'h2) begin
                    step_r[p] <= 2'd0;
                end
            end
        end
    end
    // substate shown: base, slave override or walk
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            ltssm_o[4*p +: 4] = base_i[4*p +: 4];
            lb_master_o[p] = step_r[p] == 2'd3 && !slave_i[p];
            lb_slave_o[p] = slave_i[p];
            if (slave_i[p]) begin
                ltssm_o[4*p +: 4] = 4'h7;
            end else if (step_r[p] == 2'd1) begin
                ltssm_o[4*p +: 4] = rec_r[p] ? 4'h5 : 4'h2;
            end else if (step_r[p] != 2'd0) begin
                ltssm_o[4*p +: 4] = 4'h4 + {2'b00, step_r[p]};
            end
        end
    end
endmodule

/* bench/tb_phy_loopback_test_control.sv */
// testbench: register, loopback, scrambler and training bit scenarios
`timescale 1ns/100ps
module tb_phy_loopback_test_control;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, eeprom_ld = 1'b0;
    logic port0_x2 = 1'b1, slow = 1'b0, cs, rs, hready, hreadyout, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, eeprom_test = 32'h0, eeprom_cmd = 32'h0;
    logic [31:0] hrdata, rd;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'h2;
    logic [15:0] base = 16'h0, ltssm;
    logic [3:0] slave = 4'h0, lb_master, lb_slave, serial_lb, parallel_lb, analog_lb, user_tx;
    logic [3:0] scr_bypass, tcb_scr, tcb_crx, req_cfg, req_rec, hold;
    int fail_count = 0;
    int n_tests = 0;
    localparam logic [31:0] TST = 32'h228;
    localparam logic [31:0] CMD = 32'h230;
    // 25 MHz core clock; the single slave's ready closes the loop
    always #20 clk = ~clk;
    assign hready = hreadyout;
    plt_top u_plt_top (.core_clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hready_i(hready),
        .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
        .eeprom_ld_i(eeprom_ld), .eeprom_test_i(eeprom_test), .eeprom_cmd_i(eeprom_cmd),
        .port0_x2_i(port0_x2), .ltssm_i(ltssm), .lb_master_i(lb_master), .lb_slave_i(lb_slave),
        .serial_lb_o(serial_lb), .parallel_lb_o(parallel_lb), .analog_lb_o(analog_lb),
        .user_pattern_tx_o(user_tx), .scr_bypass_o(scr_bypass), .tcb_scr_off_o(tcb_scr),
        .tcb_crx_o(tcb_crx), .lb_req_cfg_o(req_cfg), .lb_req_rec_o(req_rec), .lb_hold_o(hold));
    plt_link_partner_model u_plt_link_partner_model (.core_clk_i(clk), .rst_n_i(rst_n),
        .base_i(base), .slave_i(slave), .slow_i(slow), .lb_req_cfg_i(req_cfg),
        .lb_req_rec_i(req_rec), .lb_hold_i(hold), .ltssm_o(ltssm), .lb_master_o(lb_master),
        .lb_slave_o(lb_slave));
    // verdict and end of run
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // single transfer; bounded waits
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
        input logic [2:0] sz);
        int k;
        @(posedge clk);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w; hsize <= sz;
        for (k = 0; k == 0 || (hreadyout !== 1'b1 && k < 50); k++) @(posedge clk);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        for (k = 0; k == 0 || (hreadyout !== 1'b1 && k < 50); k++) @(posedge clk);
        rd = hrdata;
        if (k >= 50) begin fail_count++; tally_and_finish(); end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        ahb(1'b1, a, d, 3'h2);
    endtask
    task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0, 3'h2);
        chk(nm, rd, exp);
    endtask
    // let outputs land, sample mid-cycle
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic set_base(input logic [15:0] v);
        @(posedge clk);
        base <= v;
    endtask
    task automatic wait_hold(input logic v);
        int i;
        for (i = 0; i < 80 && hold[0] !== v; i++) begin
            @(negedge clk);
            cs |= req_cfg[0];
            rs |= req_rec[0];
        end
        if (i == 80) begin fail_count++; tally_and_finish(); end
    endtask
    // registers, masks, unmapped and narrow accesses, lane paths
    task automatic s_regs;
        rdc("test reset", TST, 32'h0);
        rdc("cmd reset", CMD, 32'h0);
        wr(TST, 32'hffff_ffff); // quiet detect, no self-test here
        rdc("test mask", TST, 32'hfff0_0040);
        rdc("unmapped", 32'h22c, 32'h0);
        chk("okay", 32'({hreadyout, hresp}), 32'h2);
        wt(2);
        chk("all on", 32'({serial_lb, user_tx, parallel_lb, analog_lb}), 32'hff0f);
        wr(TST, 32'h0f00_0000);
        wt(2);
        chk("digital", 32'({serial_lb, user_tx, parallel_lb, analog_lb}), 32'h00f0);
        ahb(1'b1, TST, 32'h00f0_0000, 3'h0);
        wt(2);
        chk("narrow write", 32'({serial_lb, parallel_lb}), 32'h0f);
        wr(TST, 32'h0);
        wt(2);
        chk("all off", 32'({serial_lb, user_tx, parallel_lb, analog_lb}), 32'h0);
    endtask
    // automatic slave path, lane 1 ownership, analog override
    task automatic s_slave;
        @(posedge clk);
        slave <= 4'h1;
        wt(2);
        chk("slave x2", 32'({parallel_lb, analog_lb}), 32'h30);
        @(posedge clk);
        port0_x2 <= 1'b0;
        wt(2);
        chk("slave x1", 32'({parallel_lb, analog_lb}), 32'h10);
        wr(TST, 32'h40);
        wt(2);
        chk("analog slave", 32'({parallel_lb, analog_lb}), 32'h01);
        wr(TST, 32'h0);
        @(posedge clk);
        slave <= 4'h0;
        port0_x2 <= 1'b1;
    endtask
    // master entry over either path, held while commanded
    task automatic s_master(input logic [15:0] b, input logic sl, input logic [1:0] path);
        cs = 1'b0;
        rs = 1'b0;
        set_base(b);
        slow <= sl;
        wr(CMD, 32'h1);
        wait_hold(1'b1);
        chk("entry path", 32'({cs, rs}), 32'(path));
        wt(20);
        chk("held", 32'({hold[0], ltssm[3:0]}), 32'h17);
        rdc("ready set", CMD, 32'h9);
        wr(CMD, 32'h0);
        wait_hold(1'b0);
        wt(6);
        rdc("ready clear", CMD, 32'h0);
    endtask
    // compliance receive bit per port and substate
    task automatic s_crx;
        wr(CMD, 32'h4444);
        set_base(16'h1111);
        wt(2);
        chk("crx polling", 32'(tcb_crx), 32'hf);
        set_base(16'h6464);
        wt(2);
        chk("crx entry", 32'(tcb_crx), 32'ha);
        wr(CMD, 32'h0040);
        wt(2);
        chk("crx port1", 32'(tcb_crx), 32'h2);
        wr(CMD, 32'h0);
        set_base(16'h0);
    endtask
    // scrambler disable: at once while down, at cfg complete while up
    task automatic s_scr;
        wr(CMD, 32'h2);
        wt(2);
        chk("scr down", 32'({scr_bypass, tcb_scr}), 32'h31);
        wr(CMD, 32'h0);
        wt(2);
        chk("scr off", 32'(scr_bypass), 32'h0);
        set_base(16'h0004);
        wr(CMD, 32'h2);
        wt(6);
        chk("scr pended", 32'(scr_bypass), 32'h0);
        set_base(16'h0003);
        wt(3);
        chk("scr applied", 32'(scr_bypass), 32'h3);
        wr(CMD, 32'h0);
        set_base(16'h0);
    endtask
    // serial store load, then clean up
    task automatic s_eeprom;
        @(posedge clk);
        eeprom_test <= 32'h00f0_0000;
        eeprom_cmd <= 32'h0000_0002;
        eeprom_ld <= 1'b1;
        @(posedge clk);
        eeprom_ld <= 1'b0;
        wt(2);
        chk("load", 32'({serial_lb, scr_bypass}), 32'hf3);
        rdc("load read", TST, 32'h00f0_0000);
        wr(TST, 32'h0);
        wr(CMD, 32'h0);
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        s_regs();
        s_slave();
        s_master(16'h0000, 1'b0, 2'b10);
        s_master(16'h0004, 1'b1, 2'b01);
        s_crx();
        s_scr();
        s_eeprom();
        tally_and_finish();
    end
endmodule
